//--- src/sdse_pkg.sv
// constants and types shared by the drive status encoder files
package sdse_pkg;

  // object indices on the object access port
  localparam logic [15:0] SDSE_IDX_STATUS   = 16'h6041;
  localparam logic [15:0] SDSE_IDX_QS_SEL   = 16'h605a;
  localparam logic [15:0] SDSE_IDX_SD_SEL   = 16'h605b;

  // option values after reset and their legal maxima
  localparam logic [15:0] SDSE_QS_RESET     = 16'h0002;
  localparam logic [15:0] SDSE_SD_RESET     = 16'h0000;
  localparam logic [15:0] SDSE_QS_MAX       = 16'h0004;
  localparam logic [15:0] SDSE_SD_MAX       = 16'h0001;
  localparam logic [15:0] SDSE_STATUS_RESET = 16'h0000;

  // quick stop option codes
  localparam logic [15:0] SDSE_QS_DIRECT    = 16'h0000;
  localparam logic [15:0] SDSE_QS_TORQUE    = 16'h0003;

  // operating mode codes
  localparam logic [7:0]  SDSE_MODE_PROF_POS = 8'h01;
  localparam logic [7:0]  SDSE_MODE_PROF_VEL = 8'h03;
  localparam logic [7:0]  SDSE_MODE_PT      = 8'h04;
  localparam logic [7:0]  SDSE_MODE_HOMING  = 8'h06;
  localparam logic [7:0]  SDSE_MODE_CYC_POS = 8'h08;
  localparam logic [7:0]  SDSE_MODE_CSV     = 8'h09;
  localparam logic [7:0]  SDSE_MODE_CST     = 8'h0a;

  // status word bit positions
  localparam int SDSE_BIT_POWER   = 4;
  localparam int SDSE_BIT_WARN    = 7;
  localparam int SDSE_BIT_TARGET  = 10;
  localparam int SDSE_BIT_LIMIT   = 11;
  localparam int SDSE_BIT_MODE12  = 12;
  localparam int SDSE_BIT_MODE13  = 13;
  localparam int SDSE_BIT_ABS     = 14;

  // drive state as reported by the drive state machine
  typedef enum logic [2:0] {
    SDSE_ST_NOT_READY  = 3'h0,
    SDSE_ST_SW_ON_DIS  = 3'h1,
    SDSE_ST_READY      = 3'h2,
    SDSE_ST_SWITCHED   = 3'h3,
    SDSE_ST_OP_ENABLED = 3'h4,
    SDSE_ST_QUICK_STOP = 3'h5,
    SDSE_ST_FAULT_REAC = 3'h6,
    SDSE_ST_FAULT      = 3'h7
  } sdse_drive_state_type;

  // stop ramp selection towards the motion controller
  typedef enum logic [1:0] {
    SDSE_DECEL_NONE   = 2'h0,
    SDSE_DECEL_RAMP   = 2'h1,
    SDSE_DECEL_QUICK  = 2'h2,
    SDSE_DECEL_TORQUE = 2'h3
  } sdse_decel_type;

endpackage

//--- src/sdse_stop_ctrl.sv
// stop sequencer for quick stop and shutdown behaviour
`timescale 1ns/100ps
`default_nettype none
module sdse_stop_ctrl (
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic [15:0]             qs_option,
  input  wire logic [15:0]             sd_option,
  input  wire logic                    quick_stop_req,
  input  wire logic                    shutdown_req,
  input  wire logic                    motor_stationary_flag,
  output var  sdse_pkg::sdse_decel_type decel_cmd,
  output logic                         enter_sod,
  output logic                         enter_ready,
  output logic                         stop_busy
);
  import sdse_pkg::*;

  // one-hot sequencer states
  typedef enum logic [4:0] {
    SDSE_SQ_IDLE   = 5'h01,
    SDSE_SQ_QDEC   = 5'h02,
    SDSE_SQ_QTRQ   = 5'h04,
    SDSE_SQ_SDEC   = 5'h08,
    SDSE_SQ_SPASS  = 5'h10
  } sdse_seq_type;

  sdse_seq_type seq_reg;   // current step

  // sequence steps; quick stop wins over shutdown in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      seq_reg     <= SDSE_SQ_IDLE;
      decel_cmd   <= SDSE_DECEL_NONE;
      enter_sod   <= 1'b0;
      enter_ready <= 1'b0;
    end else begin
      enter_sod   <= 1'b0;
      enter_ready <= 1'b0;
      case (seq_reg)
        SDSE_SQ_IDLE: begin
          if (quick_stop_req) begin
            if (qs_option == SDSE_QS_DIRECT) begin
              enter_sod <= 1'b1;
            end else if (qs_option == SDSE_QS_TORQUE) begin
              seq_reg   <= SDSE_SQ_QTRQ;
              decel_cmd <= SDSE_DECEL_TORQUE;
            end else begin
              seq_reg   <= SDSE_SQ_QDEC;
              decel_cmd <= SDSE_DECEL_QUICK;
            end
          end else if (shutdown_req) begin
            if (sd_option == SDSE_SD_RESET) begin
              enter_ready <= 1'b1;
            end else begin
              seq_reg   <= SDSE_SQ_SDEC;
              decel_cmd <= SDSE_DECEL_RAMP;
            end
          end
        end
        SDSE_SQ_QDEC, SDSE_SQ_QTRQ: begin
          // hold the ramp until the motor stands still
          if (motor_stationary_flag) begin
            seq_reg   <= SDSE_SQ_IDLE;
            decel_cmd <= SDSE_DECEL_NONE;
            enter_sod <= 1'b1;
          end
        end
        SDSE_SQ_SDEC: begin
          if (motor_stationary_flag) begin
            seq_reg   <= SDSE_SQ_SPASS;
            decel_cmd <= SDSE_DECEL_NONE;
            enter_sod <= 1'b1;
          end
        end
        SDSE_SQ_SPASS: begin
          // pass through switch-on-disabled, then ready
          seq_reg     <= SDSE_SQ_IDLE;
          enter_ready <= 1'b1;
        end
        default: begin
          seq_reg   <= SDSE_SQ_IDLE;
          decel_cmd <= SDSE_DECEL_NONE;
        end
      endcase
    end
  end

  assign stop_busy = (seq_reg != SDSE_SQ_IDLE);

endmodule // sdse_stop_ctrl
`default_nettype wire

//--- src/sdse_status_encoder.sv
// drive status word encoder with stop behaviour option objects
//
// Summary of operation
// - not-ready 0 in bit6, switch-on-disabled bit6 set
// - ready 0001, switched 0011, enabled 0111, bit5
// - quick stop 0111, reaction 1111, fault 1000
// - bit4 main power, bit7 warning
// - cyclic position/velocity: bit10 target reached
// - cyclic position bit13 following error; others zero
// - profile position bit10 target or halted stationary
// - profile position bit12 setpoint ack, bit13 error
// - profile velocity bit10 target or halted stationary
// - profile velocity bit12 stationary, bit13 zero
// - homing bits 13,12,10 give homing progress
// - homing error sets bit13, bit10 zero speed
// - bit11 while software position limit enabled and active
// - bit14 homed, on fieldbus, no encoder alarm
// - quick stop option 0..4, default 2, 0 direct
// - options 1,2,4 quick decel then switch-on-disabled
// - option 3 torque-limit stop then switch-on-disabled
// - shutdown option 0..1 default 0
// - shutdown 1 decel, disabled, then ready
// - status word read-only, sixteen bits
`timescale 1ns/100ps
`default_nettype none
module sdse_status_encoder (
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  // object access port
  input  wire logic                          obj_req,
  input  wire logic                          obj_wr,
  input  wire logic [15:0]                   obj_index,
  input  wire logic [15:0]                   obj_wdata,
  output logic      [15:0]                   obj_rdata,
  output logic                               obj_ack,
  output logic                               obj_err,
  // drive condition from same-clock logic
  input  wire sdse_pkg::sdse_drive_state_type drive_state,
  input  wire logic [7:0]                    op_mode,
  input  wire logic                          main_power_on,
  input  wire logic                          warning_active,
  input  wire logic                          halt_active,
  input  wire logic                          target_reached,
  input  wire logic                          following_error,
  input  wire logic                          setpoint_ack,
  input  wire logic                          motor_stationary_flag,
  input  wire logic                          homing_attained,
  input  wire logic                          homing_error,
  input  wire logic                          sw_limit_enabled,
  input  wire logic                          sw_limit_active,
  input  wire logic                          homing_complete,
  input  wire logic                          fieldbus_connected,
  input  wire logic                          encoder_alarm,
  input  wire logic                          quick_stop_req,
  input  wire logic                          shutdown_req,
  // status and stop sequencing
  output logic      [15:0]                   drive_status_word,
  output var  sdse_pkg::sdse_decel_type       decel_cmd,
  output logic                               enter_sod,
  output logic                               enter_ready
);
  import sdse_pkg::*;

  logic [15:0] quick_stop_behaviour_select_reg;  // quick stop option
  logic [15:0] shutdown_behaviour_select_reg;    // shutdown option
  logic [15:0] drive_status_word_reg;            // encoded status
  logic [15:0] drive_status_word_next;           // status from inputs
  logic [3:0]  state_low;                        // bits 3..0
  logic        state_b5;                         // quick stop bit
  logic        state_b6;                         // switch on disabled bit
  logic        mode_b10;                         // mode target bit
  logic        mode_b12;                         // mode bit 12
  logic        mode_b13;                         // mode bit 13
  logic        qs_legal;                         // write value in range
  logic        sd_legal;                         // write value in range
  logic        stop_busy;                        // sequencer active

  // drive state to bits 6,5 and 3..0
  always_comb begin
    state_low = 4'h0;
    state_b5  = 1'b0;
    state_b6  = 1'b0;
    case (drive_state)
      SDSE_ST_NOT_READY: begin
        state_low = 4'h0;
      end
      SDSE_ST_SW_ON_DIS: begin
        state_b6  = 1'b1;
      end
      SDSE_ST_READY: begin
        state_b5  = 1'b1;
        state_low = 4'h1;
      end
      SDSE_ST_SWITCHED: begin
        state_b5  = 1'b1;
        state_low = 4'h3;
      end
      SDSE_ST_OP_ENABLED: begin
        state_b5  = 1'b1;
        state_low = 4'h7;
      end
      SDSE_ST_QUICK_STOP: begin
        state_low = 4'h7;
      end
      SDSE_ST_FAULT_REAC: begin
        state_low = 4'hf;
      end
      SDSE_ST_FAULT: begin
        state_low = 4'h8;
      end
      default: begin
        state_low = 4'h0;
      end
    endcase
  end

  // mode specific bits 10, 12 and 13; unused modes read zero
  always_comb begin
    mode_b10 = 1'b0;
    mode_b12 = 1'b0;
    mode_b13 = 1'b0;
    case (op_mode)
      SDSE_MODE_CYC_POS: begin
        mode_b10 = target_reached;
        mode_b13 = following_error;
      end
      SDSE_MODE_CSV: begin
        mode_b10 = target_reached;
      end
      SDSE_MODE_PROF_POS: begin
        // halted: target bit shows standstill
        mode_b10 = halt_active ? motor_stationary_flag : target_reached;
        mode_b12 = setpoint_ack;
        mode_b13 = following_error;
      end
      SDSE_MODE_PROF_VEL: begin
        mode_b10 = halt_active ? motor_stationary_flag : target_reached;
        mode_b12 = motor_stationary_flag;
      end
      SDSE_MODE_HOMING: begin
        if (homing_error) begin
          mode_b13 = 1'b1;
          mode_b10 = motor_stationary_flag;
        end else begin
          mode_b12 = homing_attained;
          mode_b10 = target_reached;
        end
      end
      default: begin
        mode_b10 = 1'b0;
      end
    endcase
  end

  // assemble the word; bits 8, 9 and 15 stay zero
  always_comb begin
    drive_status_word_next                  = 16'h0000;
    drive_status_word_next[3:0]             = state_low;
    drive_status_word_next[5]               = state_b5;
    drive_status_word_next[6]               = state_b6;
    drive_status_word_next[SDSE_BIT_POWER]  = main_power_on;
    drive_status_word_next[SDSE_BIT_WARN]   = warning_active;
    drive_status_word_next[SDSE_BIT_TARGET] = mode_b10;
    drive_status_word_next[SDSE_BIT_LIMIT]  = sw_limit_enabled & sw_limit_active;
    drive_status_word_next[SDSE_BIT_MODE12] = mode_b12;
    drive_status_word_next[SDSE_BIT_MODE13] = mode_b13;
    drive_status_word_next[SDSE_BIT_ABS]    =
      homing_complete & fieldbus_connected & ~encoder_alarm;
  end

  // status register refreshed every cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      drive_status_word_reg <= SDSE_STATUS_RESET;
    end else begin
      drive_status_word_reg <= drive_status_word_next;
    end
  end

  assign drive_status_word = drive_status_word_reg;

  // range checks on option writes
  assign qs_legal = (obj_wdata <= SDSE_QS_MAX);
  assign sd_legal = (obj_wdata <= SDSE_SD_MAX);

  // option objects; out-of-range writes keep the old value
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      quick_stop_behaviour_select_reg <= SDSE_QS_RESET;
      shutdown_behaviour_select_reg   <= SDSE_SD_RESET;
    end else if (obj_req && obj_wr) begin
      if (obj_index == SDSE_IDX_QS_SEL && qs_legal) begin
        quick_stop_behaviour_select_reg <= obj_wdata;
      end
      if (obj_index == SDSE_IDX_SD_SEL && sd_legal) begin
        shutdown_behaviour_select_reg <= obj_wdata;
      end
    end
  end

  // object answers one cycle after the request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      obj_ack   <= 1'b0;
      obj_err   <= 1'b0;
      obj_rdata <= 16'h0000;
    end else begin
      obj_ack   <= obj_req;
      obj_err   <= 1'b0;
      obj_rdata <= 16'h0000;
      if (obj_req) begin
        case (obj_index)
          SDSE_IDX_STATUS: begin
            // read-only: writes refused
            obj_err   <= obj_wr;
            obj_rdata <= obj_wr ? 16'h0000 : drive_status_word_next;
          end
          SDSE_IDX_QS_SEL: begin
            obj_err   <= obj_wr & ~qs_legal;
            obj_rdata <= obj_wr ? 16'h0000 : quick_stop_behaviour_select_reg;
          end
          SDSE_IDX_SD_SEL: begin
            obj_err   <= obj_wr & ~sd_legal;
            obj_rdata <= obj_wr ? 16'h0000 : shutdown_behaviour_select_reg;
          end
          default: begin
            obj_err   <= 1'b1;                                   // unknown index
          end
        endcase
      end
    end
  end

  // stop sequencer for quick stop and shutdown
  sdse_stop_ctrl u_stop (
    .clk_sys               (clk_sys),
    .rstn                  (rstn),
    .qs_option             (quick_stop_behaviour_select_reg),
    .sd_option             (shutdown_behaviour_select_reg),
    .quick_stop_req        (quick_stop_req),
    .shutdown_req          (shutdown_req),
    .motor_stationary_flag (motor_stationary_flag),
    .decel_cmd             (decel_cmd),
    .enter_sod             (enter_sod),
    .enter_ready           (enter_ready),
    .stop_busy             (stop_busy)
  );

  // checks on the encoded word and the stop sequences
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_sd_start;
    !stop_busy && !quick_stop_req && shutdown_req
      && shutdown_behaviour_select_reg == SDSE_SD_MAX;
  endsequence

  sequence s_sd_finish;
    enter_sod ##1 enter_ready;
  endsequence

  a_state_codes: assert property (
    (drive_state == SDSE_ST_SW_ON_DIS) |=> (drive_status_word[6:5] == 2'b10
      && drive_status_word[3:0] == 4'h0))
    else $error("switch on disabled code wrong");

  a_enabled_code: assert property (
    (drive_state == SDSE_ST_OP_ENABLED) |=> (drive_status_word[6:5] == 2'b01
      && drive_status_word[3:0] == 4'h7))
    else $error("operation enabled code wrong");

  a_fault_code: assert property (
    (drive_state == SDSE_ST_FAULT) |=> (drive_status_word[6] == 1'b0
      && drive_status_word[3:0] == 4'h8))
    else $error("fault code wrong");

  // skip the first edge after release, the word still holds its reset value
  a_power_warn: assert property (
    $past(rstn) |-> (drive_status_word[SDSE_BIT_POWER] == $past(main_power_on)
      && drive_status_word[SDSE_BIT_WARN] == $past(warning_active)))
    else $error("power or warning bit wrong");

  a_pv_halt: assert property (
    (op_mode == SDSE_MODE_PROF_VEL && halt_active)
      |=> drive_status_word[SDSE_BIT_TARGET] == $past(motor_stationary_flag)
        && drive_status_word[SDSE_BIT_MODE13] == 1'b0)
    else $error("profile velocity halt bits wrong");

  a_homing_err: assert property (
    (op_mode == SDSE_MODE_HOMING && homing_error)
      |=> drive_status_word[SDSE_BIT_MODE13:SDSE_BIT_MODE12] == 2'b10)
    else $error("homing error bits wrong");

  a_abs_valid: assert property (
    encoder_alarm |=> !drive_status_word[SDSE_BIT_ABS])
    else $error("abs valid set under encoder alarm");

  a_reserved_zero: assert property (
    drive_status_word[9:8] == 2'b00 && !drive_status_word[15])
    else $error("reserved status bit set");

  a_qs_range: assert property (
    (obj_req && obj_wr && obj_index == SDSE_IDX_QS_SEL && !qs_legal)
      |=> obj_ack && obj_err && $stable(quick_stop_behaviour_select_reg))
    else $error("illegal quick stop option accepted");

  a_qs_direct: assert property (
    (!stop_busy && quick_stop_req
      && quick_stop_behaviour_select_reg == SDSE_QS_DIRECT)
      |=> enter_sod && decel_cmd == SDSE_DECEL_NONE)
    else $error("direct quick stop not taken");

  a_qs_torque: assert property (
    (!stop_busy && quick_stop_req
      && quick_stop_behaviour_select_reg == SDSE_QS_TORQUE)
      |=> decel_cmd == SDSE_DECEL_TORQUE && !enter_sod)
    else $error("torque stop not started");

  a_sd_sequence: assert property (
    s_sd_start ##1 (decel_cmd == SDSE_DECEL_RAMP && motor_stationary_flag)
      |=> s_sd_finish)
    else $error("shutdown sequence order wrong");

endmodule // sdse_status_encoder
`default_nettype wire

//--- sim/sdse_fieldbus_master.sv
// fieldbus master model driving the object access port
`timescale 1ns/100ps
`default_nettype none
module sdse_fieldbus_master (
  input  wire logic        clk_sys,
  output logic             obj_req,
  output logic             obj_wr,
  output logic [15:0]      obj_index,
  output logic [15:0]      obj_wdata,
  input  wire logic [15:0] obj_rdata,
  input  wire logic        obj_ack,
  input  wire logic        obj_err
);
  // idle bus before the first access
  initial begin
    obj_req   = 1'b0;
    obj_wr    = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 16'h0000;
  end
  // one access: one-cycle request, answer taken in the ack cycle
  task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd, output logic err, output logic ack);
    @(negedge clk_sys);
    obj_req   = 1'b1;
    obj_wr    = wr;
    obj_index = idx;
    obj_wdata = wd;
    @(negedge clk_sys);
    obj_req   = 1'b0;
    // released lines show the inverse, not the old value
    obj_index = ~idx;
    obj_wdata = ~wd;
    rd        = obj_rdata;
    err       = obj_err;
    ack       = obj_ack;
  endtask
endmodule // sdse_fieldbus_master
`default_nettype wire

//--- sim/sdse_status_encoder_tb_top.sv
// self-checking bench of the drive status encoder
`timescale 1ns/100ps
`default_nettype none
module sdse_status_encoder_tb_top;
  import sdse_pkg::*;
  logic                 clk_sys = 1'b0;
  logic                 rstn    = 1'b0;
  logic                 obj_req, obj_wr, obj_ack, obj_err;
  logic [15:0]          obj_index, obj_wdata, obj_rdata, drive_status_word;
  sdse_drive_state_type drive_state = SDSE_ST_NOT_READY;
  logic [7:0]           op_mode = 8'h00;
  logic                 pwr = 0, warn = 0, halt = 0, tgt = 0, ferr = 0, sack = 0, stat = 0;
  logic                 hatt = 0, herr = 0, lim_en = 0, lim_act = 0, hcomp = 0, fbus = 0;
  logic                 enc_al = 0, qreq = 0, sreq = 0, enter_sod, enter_ready;
  sdse_decel_type       decel_cmd;
  int                   mismatches = 0;
  int                   compares = 0;
  int                   qs_m = 2;
  int                   sd_m = 0;
  logic [7:0]           modes [8] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h05};

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  sdse_status_encoder u_sdse_status_encoder (
    .clk_sys(clk_sys), .rstn(rstn), .obj_req(obj_req), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .obj_ack(obj_ack), .obj_err(obj_err), .drive_state(drive_state), .op_mode(op_mode),
    .main_power_on(pwr), .warning_active(warn), .halt_active(halt),
    .target_reached(tgt), .following_error(ferr), .setpoint_ack(sack),
    .motor_stationary_flag(stat), .homing_attained(hatt), .homing_error(herr),
    .sw_limit_enabled(lim_en), .sw_limit_active(lim_act), .homing_complete(hcomp),
    .fieldbus_connected(fbus), .encoder_alarm(enc_al), .quick_stop_req(qreq),
    .shutdown_req(sreq), .drive_status_word(drive_status_word), .decel_cmd(decel_cmd),
    .enter_sod(enter_sod), .enter_ready(enter_ready));

  sdse_fieldbus_master u_sdse_fieldbus_master (
    .clk_sys(clk_sys), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));

  // reference status word from the current inputs
  function automatic logic [15:0] exp_word();
    logic [15:0] w;
    logic        t;
    w = 16'h0000;
    t = halt ? stat : tgt;
    case (drive_state)
      SDSE_ST_SW_ON_DIS:  w[7:0] = 8'h40;
      SDSE_ST_READY:      w[7:0] = 8'h21;
      SDSE_ST_SWITCHED:   w[7:0] = 8'h23;
      SDSE_ST_OP_ENABLED: w[7:0] = 8'h27;
      SDSE_ST_QUICK_STOP: w[7:0] = 8'h07;
      SDSE_ST_FAULT_REAC: w[7:0] = 8'h0f;
      SDSE_ST_FAULT:      w[7:0] = 8'h08;
      default:            w[7:0] = 8'h00;
    endcase
    w[4] = pwr;
    w[7] = warn;
    case (op_mode)
      SDSE_MODE_CYC_POS:  {w[13], w[10]} = {ferr, tgt};
      SDSE_MODE_CSV:      w[10] = tgt;
      SDSE_MODE_PROF_POS: {w[13], w[12], w[10]} = {ferr, sack, t};
      SDSE_MODE_PROF_VEL: {w[12], w[10]} = {stat, t};
      SDSE_MODE_HOMING:
        {w[13], w[12], w[10]} = herr ? {2'b10, stat} : {1'b0, hatt, tgt};
      default:       w = w;
    endcase
    w[11] = lim_en & lim_act;
    w[14] = hcomp & fbus & ~enc_al;
    return w;
  endfunction

  // one comparison with report
  task automatic check16(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // verdict and end of run
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // object access through the master model, answer checked
  task automatic obj(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                     input logic [15:0] er, input logic ee);
    logic [15:0] rd;
    logic        err, ack;
    u_sdse_fieldbus_master.access(wr, idx, wd, rd, err, ack);
    check16("obj_ack", 16'h0001, {15'h0, ack});
    check16("obj_err", {15'h0, ee}, {15'h0, err});
    if (!wr && !ee) check16("obj_rdata", er, rd);
  endtask

  // one-cycle request pulse; returns in the answer cycle
  task automatic pulse(input logic quick);
    @(negedge clk_sys);
    if (quick) qreq = 1'b1;
    else sreq = 1'b1;
    @(negedge clk_sys);
    qreq = 1'b0;
    sreq = 1'b0;
  endtask

  // status word compared after every edge out of reset
  always @(posedge clk_sys) begin
    #1;
    if (rstn) check16("drive_status_word", exp_word(), drive_status_word);
  end

  // watchdog cuts a hang short
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    void'($urandom(7360));
    repeat (6) @(posedge clk_sys);
    check16("reset word", SDSE_STATUS_RESET, drive_status_word);
    @(negedge clk_sys);
    rstn = 1'b1;
    obj(0, SDSE_IDX_QS_SEL, 0, SDSE_QS_RESET, 0);
    obj(0, SDSE_IDX_SD_SEL, 0, SDSE_SD_RESET, 0);
    for (int i = 0; i < 7; i++) begin
      obj(1, SDSE_IDX_QS_SEL, 16'(i), 0, i > 4);
      if (i <= 4) qs_m = i;
      obj(0, SDSE_IDX_QS_SEL, 0, 16'(qs_m), 0);
      obj(1, SDSE_IDX_SD_SEL, 16'(i), 0, i > 1);
      if (i <= 1) sd_m = i;
      obj(0, SDSE_IDX_SD_SEL, 0, 16'(sd_m), 0);
    end
    obj(1, SDSE_IDX_STATUS, 16'hffff, 0, 1);
    obj(0, 16'h605c, 0, 0, 1);
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      {pwr, warn, tgt, ferr, sack, stat, hatt, herr, lim_en, lim_act} = 10'($urandom);
      {hcomp, fbus, enc_al} = 3'($urandom);
      halt = 1'($urandom);
      drive_state = sdse_drive_state_type'(3'($urandom));
      op_mode = modes[$urandom % 8];
      if (i % 500 == 7) obj(0, SDSE_IDX_STATUS, 0, exp_word(), 0);
    end
    stat = 1'b0;
    for (int o = 0; o < 5; o++) begin
      obj(1, SDSE_IDX_QS_SEL, 16'(o), 0, 0);
      pulse(1);
      if (o == 0) check16("enter_sod", 16'h0001, {15'h0, enter_sod});
      else check16("decel_cmd", (o == 3) ? 16'h3 : 16'h2, {14'h0, decel_cmd});
      if (o != 0) begin
        stat = 1'b1;
        @(negedge clk_sys);
        check16("enter_sod", 16'h0001, {15'h0, enter_sod});
        check16("decel_cmd", 16'h0000, {14'h0, decel_cmd});
        stat = 1'b0;
      end
      @(negedge clk_sys);
    end
    obj(1, SDSE_IDX_SD_SEL, 16'h0000, 0, 0);
    pulse(0);
    check16("enter_ready", 16'h0001, {15'h0, enter_ready});
    obj(1, SDSE_IDX_SD_SEL, 16'h0001, 0, 0);
    pulse(0);
    check16("decel_cmd", 16'h0001, {14'h0, decel_cmd});
    stat = 1'b1;
    @(negedge clk_sys);
    check16("enter_sod", 16'h0001, {15'h0, enter_sod});
    stat = 1'b0;
    @(negedge clk_sys);
    check16("enter_ready", 16'h0001, {15'h0, enter_ready});
    repeat (3) @(negedge clk_sys);
    print_verdict();
  end
endmodule // sdse_status_encoder_tb_top
`default_nettype wire
